// ===== hdl/ctmc_mode_ctrl.sv
// CAN transceiver mode control: mode state machine and its three registers
// Contract
// - Biased standby drops to standby after bus silence beyond timeout.
// - Active modes go biased standby, or standby if bus idle, when device sleeps or stands by.
// - Active modes go biased standby, or standby if bus idle, when device normal and target standby.
// - Standby goes biased when device normal, target normal, VCC undervoltage.
// - Standby goes biased on any bus wake-up event.
// - Silent receives, transmitter off, bus recessive, biasing kept.
// - Silent entered when device normal and target silent.
// - Receive recessive clamping forces and holds silent; reduced normal ignores it until VCC recovery debounce.
// - Undervoltage in silent holds silent until microcontroller reset mode.
// - Normal entered with device normal, target normal, no undervoltage, no clamping; reduced normal enters it even with clamping.
// - Reduced normal returns to normal after VCC recovery debounce.
// - Transmit input held low keeps silent until it goes high.
// - Normal enters reduced normal after debounced VCC undervoltage; transmitter off.
// - Target field 00 standby, 01 normal, 11 silent; never changed by hardware.
// - Fast-frame passive bit resets to one and steers fast-frame handling.
// - Config-valid bit clears after any selective-wake configuration write.
// - Selective wake enable follows the host's written value.
// - Transmitter ready flag is one when transmitter enabled.
// - Selective wake error flag zero only if no frame error, valid, oscillator ok.
// - Selective wake config flag follows the config-valid bit.
// - Bus idle flag is one after silence timeout.
// - Transmit timeout flag is one while transmitter disabled by dominant timeout.
// - Device mode 001 sleep, 111 normal, undefined codes mean standby.
// - In standby and biased standby, wake pattern drives receive output low, whatever the selective wake enable.
// - Bus failure register: bit 1 dominant timeout, bit 0 short.
`timescale 1ns/1ps
module ctmc_mode_ctrl #(
    parameter int SILENCE_CYC = ctmc_pkg::SILENCE_CYC,
    parameter int UV_DEBOUNCE_CYC = ctmc_pkg::UV_DEBOUNCE_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic sw_cfg_write,
    input wire logic [2:0] device_mode_select,
    input wire logic uc_reset_mode,
    input wire logic vcc_uv,
    input wire logic rxd_clamp,
    input wire logic txd,
    input wire logic bus_rx,
    input wire logic bus_activity,
    input wire logic bus_wake_event,
    input wire logic bus_wake_pattern,
    input wire logic selective_wake_frame_error,
    input wire logic selective_wake_osc_ok,
    input wire logic txd_dom_timeout,
    input wire logic bus_dominant_timeout_flag,
    input wire logic bus_short_flag,
    output logic rxd,
    output logic tx_enable,
    output logic bias_enable,
    output logic [2:0] trx_state,
    output logic fast_frame_passive_enable,
    output logic selective_wake_enable
);
    ctmc_pkg::ctmc_state_e state_r;
    ctmc_pkg::ctmc_state_e state_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rxd_r;
    logic rxd_nxt;
    logic silent_lock_r;
    logic silent_lock_nxt;
    logic bus_idle;
    logic uv_long;
    logic vcc_ok_long;
    logic [7:0] status;
    logic [2:0] dev_mode;
    logic [1:0] target;
    logic dev_normal;

    // Undefined codes fall back to standby
    function automatic logic [2:0] dev_decode(input logic [2:0] code);
        if (code == ctmc_pkg::DEV_SLEEP || code == ctmc_pkg::DEV_NORMAL)
        begin
            return code;
        end
        return ctmc_pkg::DEV_STANDBY;
    endfunction

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    ctmc_timer #(.LIMIT(SILENCE_CYC), .W(32)) u_silence (
        .clk(clk),
        .resetn(resetn),
        .cond(!bus_activity),
        .expired(bus_idle)
    );

    ctmc_timer #(.LIMIT(UV_DEBOUNCE_CYC), .W(32)) u_uv (
        .clk(clk),
        .resetn(resetn),
        .cond(vcc_uv),
        .expired(uv_long)
    );

    ctmc_timer #(.LIMIT(UV_DEBOUNCE_CYC), .W(32)) u_vok (
        .clk(clk),
        .resetn(resetn),
        .cond(!vcc_uv),
        .expired(vcc_ok_long)
    );

    assign dev_mode = dev_decode(device_mode_select);
    assign dev_normal = (dev_mode == ctmc_pkg::DEV_NORMAL);
    assign target = ctrl_r[1:0];

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        silent_lock_nxt = silent_lock_r;
        if (uc_reset_mode)
        begin
            silent_lock_nxt = 1'b0;
        end
        case (state_r)
            ctmc_pkg::CTMC_STANDBY:
            begin
                if (bus_wake_event)
                begin
                    state_nxt = ctmc_pkg::CTMC_BIASED;
                end
                else if (dev_normal && target == ctmc_pkg::TGT_NORMAL && vcc_uv)
                begin
                    state_nxt = ctmc_pkg::CTMC_BIASED;
                end
                else if (dev_normal && target == ctmc_pkg::TGT_SILENT)
                begin
                    state_nxt = ctmc_pkg::CTMC_SILENT;
                end
                else if (dev_normal && target == ctmc_pkg::TGT_NORMAL)
                begin
                    state_nxt = (rxd_clamp || !txd) ? ctmc_pkg::CTMC_SILENT : ctmc_pkg::CTMC_NORMAL;
                end
            end
            ctmc_pkg::CTMC_BIASED:
            begin
                if (bus_idle)
                begin
                    state_nxt = ctmc_pkg::CTMC_STANDBY;
                end
                else if (dev_normal && target == ctmc_pkg::TGT_SILENT)
                begin
                    state_nxt = ctmc_pkg::CTMC_SILENT;
                end
                else if (dev_normal && target == ctmc_pkg::TGT_NORMAL && !vcc_uv)
                begin
                    state_nxt = (rxd_clamp || !txd) ? ctmc_pkg::CTMC_SILENT : ctmc_pkg::CTMC_NORMAL;
                end
            end
            ctmc_pkg::CTMC_SILENT, ctmc_pkg::CTMC_NORMAL, ctmc_pkg::CTMC_REDUCED:
            begin
                if (state_r == ctmc_pkg::CTMC_SILENT && vcc_uv)
                begin
                    silent_lock_nxt = !uc_reset_mode;
                end
                if (!dev_normal || target == ctmc_pkg::TGT_STANDBY)
                begin
                    state_nxt = bus_idle ? ctmc_pkg::CTMC_STANDBY : ctmc_pkg::CTMC_BIASED;
                    silent_lock_nxt = 1'b0;
                end
                else if (target == ctmc_pkg::TGT_SILENT)
                begin
                    state_nxt = ctmc_pkg::CTMC_SILENT;
                end
                else if (state_r == ctmc_pkg::CTMC_REDUCED)
                begin
                    if (vcc_ok_long)
                    begin
                        state_nxt = ctmc_pkg::CTMC_NORMAL;
                    end
                end
                // Low transmit input in normal is ordinary dominant data, not a stuck line
                else if (rxd_clamp || (!txd && state_r != ctmc_pkg::CTMC_NORMAL) || silent_lock_nxt)
                begin
                    state_nxt = ctmc_pkg::CTMC_SILENT;
                end
                else if (state_r == ctmc_pkg::CTMC_NORMAL && uv_long)
                begin
                    state_nxt = ctmc_pkg::CTMC_REDUCED;
                end
                else if (!vcc_uv)
                begin
                    state_nxt = ctmc_pkg::CTMC_NORMAL;
                end
            end
            default:
            begin
                state_nxt = ctmc_pkg::CTMC_STANDBY;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers and receive output
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (reg_wr && reg_addr == ctmc_pkg::CTRL_ADDR)
        begin
            ctrl_nxt = reg_wdata & ctmc_pkg::CTRL_WMASK;
        end
        if (sw_cfg_write)
        begin
            ctrl_nxt[ctmc_pkg::CTRL_CFGOK_BIT] = 1'b0;
        end
        status = '0;
        status[ctmc_pkg::STAT_TXRDY_BIT] = (state_r == ctmc_pkg::CTMC_NORMAL) && !txd_dom_timeout;
        status[ctmc_pkg::STAT_SWERR_BIT] = selective_wake_frame_error || !ctrl_r[ctmc_pkg::CTRL_CFGOK_BIT]
            || !selective_wake_osc_ok;
        status[ctmc_pkg::STAT_SWCFG_BIT] = ctrl_r[ctmc_pkg::CTRL_CFGOK_BIT];
        status[ctmc_pkg::STAT_OSC_BIT] = selective_wake_osc_ok;
        status[ctmc_pkg::STAT_IDLE_BIT] = bus_idle;
        status[ctmc_pkg::STAT_TXTO_BIT] = txd_dom_timeout;
        case (reg_addr)
            ctmc_pkg::CTRL_ADDR: rdata_nxt = ctrl_r;
            ctmc_pkg::STAT_ADDR: rdata_nxt = status;
            ctmc_pkg::BFAIL_ADDR: rdata_nxt = {6'h00, bus_dominant_timeout_flag, bus_short_flag};
            default: rdata_nxt = 8'h00;
        endcase
        // Low-power modes show only the wake request on receive
        if (state_r == ctmc_pkg::CTMC_STANDBY || state_r == ctmc_pkg::CTMC_BIASED)
        begin
            rxd_nxt = !bus_wake_pattern;
        end
        else
        begin
            rxd_nxt = bus_rx;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_r <= ctmc_pkg::CTMC_STANDBY;
            silent_lock_r <= 1'b0;
            ctrl_r <= ctmc_pkg::CTRL_RESET;
            rdata_r <= 8'h00;
            rxd_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            silent_lock_r <= silent_lock_nxt;
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            rxd_r <= rxd_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign rxd = rxd_r;
    // Transmitter only in normal; silent and reduced release the bus
    assign tx_enable = (state_r == ctmc_pkg::CTMC_NORMAL) && !txd_dom_timeout;
    assign bias_enable = (state_r != ctmc_pkg::CTMC_STANDBY);
    assign trx_state = state_r;
    assign fast_frame_passive_enable = ctrl_r[ctmc_pkg::CTRL_FDP_BIT];
    assign selective_wake_enable = ctrl_r[ctmc_pkg::CTRL_SWE_BIT];
endmodule // ctmc_mode_ctrl

// ===== hdl/ctmc_timer.sv
// Persistence timer: flags when a condition has held for longer than a cycle count
`timescale 1ns/1ps
module ctmc_timer #(
    parameter int LIMIT = 2000,
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cond,
    output logic expired
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic exp_r;
    logic exp_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (!cond)
        begin
            cnt_nxt = '0;
        end
        else if (cnt_r < W'(LIMIT))
        begin
            cnt_nxt = cnt_r + W'(1);
        end
        else
        begin
            exp_nxt = 1'b1;
        end
        if (!cond)
        begin
            exp_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expired = exp_r;
endmodule // ctmc_timer

// ===== include/ctmc_pkg.sv
// Package: register map, field positions, reset values, modes and timing of the CAN transceiver mode control
package ctmc_pkg;
    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h20;
    localparam logic [7:0] STAT_ADDR = 8'h22;
    localparam logic [7:0] BFAIL_ADDR = 8'h33;
    localparam logic [7:0] CTRL_RESET = 8'h41;
    localparam logic [7:0] STAT_RESET = 8'h48;
    localparam logic [7:0] BFAIL_RESET = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_FDP_BIT = 6;
    localparam int CTRL_CFGOK_BIT = 5;
    localparam int CTRL_SWE_BIT = 4;
    localparam int STAT_TXRDY_BIT = 7;
    localparam int STAT_SWERR_BIT = 6;
    localparam int STAT_SWCFG_BIT = 5;
    localparam int STAT_OSC_BIT = 4;
    localparam int STAT_IDLE_BIT = 3;
    localparam int STAT_TXTO_BIT = 0;
    localparam int BFAIL_DOM_BIT = 1;
    localparam int BFAIL_SHORT_BIT = 0;
    // Writable bits of the control register
    localparam logic [7:0] CTRL_WMASK = 8'h73;
    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] DEV_SLEEP = 3'h1;
    localparam logic [2:0] DEV_STANDBY = 3'h4;
    localparam logic [2:0] DEV_NORMAL = 3'h7;
    localparam logic [1:0] TGT_STANDBY = 2'h0;
    localparam logic [1:0] TGT_NORMAL = 2'h1;
    localparam logic [1:0] TGT_SILENT = 2'h3;

    typedef enum logic [2:0] {
        CTMC_STANDBY = 3'b000,
        CTMC_BIASED = 3'b001,
        CTMC_SILENT = 3'b010,
        CTMC_NORMAL = 3'b011,
        CTMC_REDUCED = 3'b100
    } ctmc_state_e;

    // ------------------------------------------------------------
    // Timing at 200 MHz
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int SILENCE_US = 1000;
    localparam int SILENCE_CYC = SILENCE_US * CLK_MHZ;
    localparam int UV_DEBOUNCE_US = 10;
    localparam int UV_DEBOUNCE_CYC = UV_DEBOUNCE_US * CLK_MHZ;
endpackage

// ===== sim/can_transceiver_mode_control_tb.sv
// Self-checking bench of the CAN transceiver mode control
`timescale 1ns/1ps
module can_transceiver_mode_control_tb;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, sw_cfg_write = 1'b0, uc_reset_mode = 1'b0;
    logic vcc_uv = 1'b0, rxd_clamp = 1'b0, bus_rx = 1'b1, bus_activity = 1'b0, wake_ev = 1'b0;
    logic wake_pat = 1'b0, frame_err = 1'b0, osc_ok = 1'b0, dom_to = 1'b0, bus_dom = 1'b0;
    logic bus_sh = 1'b0, txd_stuck = 1'b0;
    logic txd, rxd, tx_enable, bias_enable, fast_en, sw_en;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [2:0] dev = 3'h4, trx_state;
    int errors = 0, check_count = 0;
    ctmc_host_model host (.clk(clk), .force_dominant(txd_stuck), .txd(txd));
    ctmc_mode_ctrl #(.SILENCE_CYC(20), .UV_DEBOUNCE_CYC(8)) dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sw_cfg_write(sw_cfg_write), .device_mode_select(dev),
        .uc_reset_mode(uc_reset_mode), .vcc_uv(vcc_uv), .rxd_clamp(rxd_clamp), .txd(txd), .bus_rx(bus_rx),
        .bus_activity(bus_activity), .bus_wake_event(wake_ev), .bus_wake_pattern(wake_pat),
        .selective_wake_frame_error(frame_err), .selective_wake_osc_ok(osc_ok), .txd_dom_timeout(dom_to),
        .bus_dominant_timeout_flag(bus_dom), .bus_short_flag(bus_sh), .rxd(rxd), .tx_enable(tx_enable),
        .bias_enable(bias_enable), .trx_state(trx_state), .fast_frame_passive_enable(fast_en),
        .selective_wake_enable(sw_en)
    );
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 chk(n, e, reg_rdata & m);
    endtask
    // Bounded wait for a mode; running out ends the run
    task automatic wst(input logic [2:0] s, input string n);
        int i;
        for (i = 0; i < 200 && trx_state !== s; i++) @(posedge clk) #1;
        chk(n, {5'h00, s}, {5'h00, trx_state});
        if (i == 200) give_verdict();
    endtask
    task automatic t_reset();
        repeat (30) @(posedge clk);
        rd(8'h20, 8'hff, ctmc_pkg::CTRL_RESET, "ctrl reset");
        rd(8'h22, 8'hff, ctmc_pkg::STAT_RESET, "status reset");
        rd(8'h33, 8'hff, 8'h00, "failure reset");
        rd(8'h10, 8'hff, 8'h00, "unmapped");
        chk("fast passive", 8'h01, {7'h00, fast_en});
    endtask
    task automatic t_regs();
        wr(8'h20, 8'hff);
        rd(8'h20, 8'hff, ctmc_pkg::CTRL_WMASK, "ctrl write");
        chk("wake enable", 8'h01, {7'h00, sw_en});
        @(posedge clk);
        sw_cfg_write <= 1'b1;
        @(posedge clk);
        sw_cfg_write <= 1'b0;
        rd(8'h20, 8'hff, 8'h53, "config clear");
        rd(8'h22, 8'h60, 8'h40, "config invalid");
        @(posedge clk);
        osc_ok <= 1'b1;
        wr(8'h21, 8'h00);
        rd(8'h20, 8'hff, 8'h53, "stray write");
        wr(8'h20, 8'h21);
        rd(8'h22, 8'h70, 8'h30, "config valid");
        @(posedge clk);
        frame_err <= 1'b1;
        rd(8'h22, 8'h40, 8'h40, "frame error");
        @(posedge clk);
        frame_err <= 1'b0;
        chk("wake enable off", 8'h00, {7'h00, sw_en});
        chk("fast passive off", 8'h00, {7'h00, fast_en});
    endtask
    task automatic t_normal();
        @(posedge clk);
        bus_activity <= 1'b1;
        dev <= ctmc_pkg::DEV_NORMAL;
        wst(ctmc_pkg::CTMC_NORMAL, "enter normal");
        rd(8'h22, 8'h81, 8'h80, "tx ready");
        @(posedge clk);
        dom_to <= 1'b1;
        bus_dom <= 1'b1;
        rd(8'h22, 8'h81, 8'h01, "tx timeout");
        rd(8'h33, 8'hff, 8'h02, "dominant flag");
        @(posedge clk);
        bus_sh <= 1'b1;
        rd(8'h33, 8'hff, 8'h03, "short flag");
        @(posedge clk);
        dom_to <= 1'b0;
        bus_dom <= 1'b0;
        bus_sh <= 1'b0;
        txd_stuck <= 1'b1;
        repeat (12) @(posedge clk);
        #1 chk("dominant in normal", {5'h00, ctmc_pkg::CTMC_NORMAL}, {5'h00, trx_state});
        @(posedge clk);
        txd_stuck <= 1'b0;
    endtask
    task automatic t_silent();
        wr(8'h20, 8'h20);
        wst(ctmc_pkg::CTMC_BIASED, "target standby");
        wr(8'h20, 8'h23);
        wst(ctmc_pkg::CTMC_SILENT, "target silent");
        chk("silent flags", 8'h02, {6'h00, bias_enable, tx_enable});
        @(posedge clk);
        txd_stuck <= 1'b1;
        wr(8'h20, 8'h21);
        repeat (12) @(posedge clk);
        #1 chk("txd low", {5'h00, ctmc_pkg::CTMC_SILENT}, {5'h00, trx_state});
        @(posedge clk);
        txd_stuck <= 1'b0;
        wst(ctmc_pkg::CTMC_NORMAL, "txd released");
    endtask
    task automatic t_reduced();
        @(posedge clk);
        vcc_uv <= 1'b1;
        wst(ctmc_pkg::CTMC_REDUCED, "reduced");
        chk("reduced tx", 8'h00, {7'h00, tx_enable});
        @(posedge clk);
        vcc_uv <= 1'b0;
        wst(ctmc_pkg::CTMC_NORMAL, "recovered");
    endtask
    task automatic t_clamp();
        @(posedge clk);
        rxd_clamp <= 1'b1;
        bus_rx <= 1'b0;
        wst(ctmc_pkg::CTMC_SILENT, "clamp");
        repeat (2) @(posedge clk);
        #1 chk("silent rx", 8'h00, {7'h00, rxd});
        @(posedge clk);
        vcc_uv <= 1'b1;
        bus_rx <= 1'b1;
        repeat (12) @(posedge clk);
        vcc_uv <= 1'b0;
        rxd_clamp <= 1'b0;
        repeat (12) @(posedge clk);
        #1 chk("uv hold", {5'h00, ctmc_pkg::CTMC_SILENT}, {5'h00, trx_state});
        @(posedge clk);
        uc_reset_mode <= 1'b1;
        @(posedge clk);
        uc_reset_mode <= 1'b0;
        wst(ctmc_pkg::CTMC_NORMAL, "reset mode");
    endtask
    task automatic t_standby();
        @(posedge clk);
        dev <= 3'h2;
        wst(ctmc_pkg::CTMC_BIASED, "undefined mode");
        @(posedge clk);
        bus_activity <= 1'b0;
        wst(ctmc_pkg::CTMC_STANDBY, "silence");
        rd(8'h22, 8'h08, 8'h08, "bus idle");
        @(posedge clk);
        wake_ev <= 1'b1;
        wake_pat <= 1'b1;
        wst(ctmc_pkg::CTMC_BIASED, "wake");
        repeat (2) @(posedge clk);
        #1 chk("wake rxd", 8'h00, {7'h00, rxd});
        @(posedge clk);
        wake_ev <= 1'b0;
        wake_pat <= 1'b0;
        bus_activity <= 1'b1;
        dev <= ctmc_pkg::DEV_NORMAL;
        wst(ctmc_pkg::CTMC_NORMAL, "normal again");
        @(posedge clk);
        dev <= ctmc_pkg::DEV_SLEEP;
        wst(ctmc_pkg::CTMC_BIASED, "sleep");
        @(posedge clk);
        bus_activity <= 1'b0;
        wst(ctmc_pkg::CTMC_STANDBY, "silence again");
        @(posedge clk);
        vcc_uv <= 1'b1;
        dev <= ctmc_pkg::DEV_NORMAL;
        wst(ctmc_pkg::CTMC_BIASED, "undervoltage bias");
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_normal();
        t_silent();
        t_reduced();
        t_clamp();
        t_standby();
        give_verdict();
    end
endmodule // can_transceiver_mode_control_tb

// ===== sim/ctmc_host_model.sv
// Host side model: protocol controller transmit line
`timescale 1ns/1ps
module ctmc_host_model (
    input wire logic clk,
    input wire logic force_dominant,
    output logic txd
);
    // A controller stuck low keeps the line dominant until released
    always_ff @(posedge clk)
    begin
        txd <= !force_dominant;
    end
endmodule // ctmc_host_model

// ===== sim/ctmc_mode_ctrl_properties.sv
// Concurrent checks of the CAN transceiver mode control at its ports
`timescale 1ns/1ps
module ctmc_props_chk #(
    parameter int SILENCE_CYC = 20,
    parameter int UV_DEBOUNCE_CYC = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [2:0] device_mode_select,
    input wire logic uc_reset_mode,
    input wire logic vcc_uv,
    input wire logic rxd_clamp,
    input wire logic txd,
    input wire logic bus_activity,
    input wire logic bus_wake_event,
    input wire logic tx_enable,
    input wire logic bias_enable,
    input wire logic [2:0] trx_state
);
    // ------------------------------------------
    // Mirror of host target, latch and idle time
    // ------------------------------------------
    logic [1:0] tgt_r;
    logic [1:0] tgt_nxt;
    logic uvs_r;
    logic uvs_nxt;
    int idle_r;
    int idle_nxt;
    logic ok;
    always_comb
    begin
        tgt_nxt = (reg_wr && reg_addr == ctmc_pkg::CTRL_ADDR) ? reg_wdata[1:0] : tgt_r;
        idle_nxt = bus_activity ? 0 : idle_r + 1;
        // Set early so the normal-entry check never outruns the design latch
        uvs_nxt = (uvs_r || (vcc_uv && trx_state == ctmc_pkg::CTMC_SILENT)) && !uc_reset_mode
            && trx_state > ctmc_pkg::CTMC_BIASED;
        ok = device_mode_select == ctmc_pkg::DEV_NORMAL && !vcc_uv && trx_state != ctmc_pkg::CTMC_REDUCED;
    end
    always_ff @(posedge clk)
    begin
        tgt_r <= resetn ? tgt_nxt : ctmc_pkg::TGT_NORMAL;
        uvs_r <= resetn && uvs_nxt;
        idle_r <= resetn ? idle_nxt : 0;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_silent_bias;
        trx_state == ctmc_pkg::CTMC_SILENT |-> bias_enable && !tx_enable;
    endproperty
    a_silent_bias: assert property (p_silent_bias) else $error("silent mode unbiased or transmitting");
    property p_tx_normal_only;
        tx_enable |-> trx_state == ctmc_pkg::CTMC_NORMAL;
    endproperty
    a_tx_normal_only: assert property (p_tx_normal_only) else $error("transmitter on outside normal");
    property p_to_silent;
        (ok && tgt_r == ctmc_pkg::TGT_SILENT) [*5] |-> trx_state == ctmc_pkg::CTMC_SILENT;
    endproperty
    a_to_silent: assert property (p_to_silent) else $error("silent target not reached");
    property p_clamp;
        (ok && tgt_r == ctmc_pkg::TGT_NORMAL && rxd_clamp) [*5] |-> trx_state == ctmc_pkg::CTMC_SILENT;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamping did not force silent");
    property p_to_normal;
        (ok && tgt_r == ctmc_pkg::TGT_NORMAL && txd && !rxd_clamp && !uvs_r) [*5]
            |-> trx_state == ctmc_pkg::CTMC_NORMAL;
    endproperty
    a_to_normal: assert property (p_to_normal) else $error("normal target not reached");
    property p_txd_low;
        ok && tgt_r == ctmc_pkg::TGT_NORMAL && !txd && trx_state != ctmc_pkg::CTMC_NORMAL
            |=> trx_state != ctmc_pkg::CTMC_NORMAL;
    endproperty
    a_txd_low: assert property (p_txd_low) else $error("stuck transmit line not held silent");
    property p_to_biased;
        bus_activity [*3] ##0 (trx_state inside {ctmc_pkg::CTMC_SILENT, ctmc_pkg::CTMC_NORMAL,
            ctmc_pkg::CTMC_REDUCED} && (device_mode_select != ctmc_pkg::DEV_NORMAL
            || tgt_r == ctmc_pkg::TGT_STANDBY)) |-> ##[1:3] trx_state == ctmc_pkg::CTMC_BIASED;
    endproperty
    a_to_biased: assert property (p_to_biased) else $error("active mode did not drop to biased");
    property p_silence;
        (!bus_wake_event) [*4] ##0 (idle_r > SILENCE_CYC + 3 && device_mode_select != ctmc_pkg::DEV_NORMAL)
            |-> trx_state != ctmc_pkg::CTMC_BIASED;
    endproperty
    a_silence: assert property (p_silence) else $error("biased kept after bus silence");
endmodule // ctmc_props_chk

bind ctmc_mode_ctrl ctmc_props_chk #(.SILENCE_CYC(SILENCE_CYC), .UV_DEBOUNCE_CYC(UV_DEBOUNCE_CYC)) u_props (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .device_mode_select(device_mode_select), .uc_reset_mode(uc_reset_mode), .vcc_uv(vcc_uv),
    .rxd_clamp(rxd_clamp), .txd(txd), .bus_activity(bus_activity), .bus_wake_event(bus_wake_event),
    .tx_enable(tx_enable), .bias_enable(bias_enable), .trx_state(trx_state)
);
